// ### design/csr_core_state.sv
// architectural state of the core: register file, status word, masks, mode
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module csr_core_state
   import csr_pkg::*;
#(
   parameter int XW = XLEN,
   parameter int PW = PRIO_W
) (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // general register file port
   input  wire logic [3:0]        gpr_waddr,
   input  wire logic [XW-1:0]     gpr_wdata,
   input  wire logic              gpr_we,
   input  wire logic              gpr_narrow,
   input  wire logic [3:0]        gpr_raddr,
   output logic      [XW-1:0]     gpr_rdata,
   // program flow
   input  wire logic              pc_load,
   input  wire logic [XW-1:0]     pc_target,
   input  wire logic              pc_step,
   input  wire logic              pc_step_wide,
   input  wire logic              call_req,
   output logic      [XW-1:0]     fetch_addr,
   // flags from the alu
   input  wire logic              flags_we,
   input  wire logic [4:0]        flags_in,
   // exception entry and return
   input  wire logic              exc_entry,
   input  wire logic [EXC_W-1:0]  exc_num,
   input  wire logic              exc_return,
   input  wire logic              exc_ret_thread,
   // pending interrupt presented for masking
   input  wire logic              irq_pend,
   input  wire logic [EXC_W-1:0]  irq_num,
   input  wire logic [PW-1:0]     irq_prio,
   output logic                   irq_take,
   // special register port
   input  wire logic [7:0]        sreg_addr,
   input  wire logic [XW-1:0]     sreg_wdata,
   input  wire logic              sreg_wr,
   input  wire logic              sreg_rd,
   input  wire logic              restricted_op,
   output logic      [XW-1:0]     sreg_rdata,
   // data access address translation
   input  wire logic [XW-1:0]     data_addr,
   output logic      [XW-1:0]     mem_addr,
   output logic      [4:0]        mem_bit,
   output logic                   mem_bitband,
   // status
   output logic                   fault_req,
   output logic                   handler_mode,
   output logic                   user_level
);
   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   initial begin
      if (XW != 32) $error("core state supports 32-bit registers only");
      if (PW < 1 || PW > 9) $error("priority width must be 1..9");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   csr_state_type      state_r;
   logic [XW-1:0]      gpr_r [0:12];
   logic [XW-1:0]      msp_r;
   logic [XW-1:0]      psp_r;
   logic [XW-1:0]      lr_r;
   logic [XW-1:0]      pc_r;
   logic [4:0]         flags_r;
   logic [EXC_W-1:0]   exc_r;
   logic [5:0]         ici_r;
   logic [1:0]         it_r;
   logic               gmask_r;
   logic               fmask_r;
   logic [PW-1:0]      prio_r;
   logic [1:0]         ctrl_r;
   logic               in_handler;
   logic               is_user;
   logic               use_psp;
   logic               priv_deny;
   logic               tbit_clear;
   logic               fault_nxt;
   logic               status_wr;
   logic [XW-1:0]      status_word;
   logic [XW-1:0]      sp_view;
   logic [XW-1:0]      next_pc;
   logic               hi_denied;
   logic               mask_block;

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   // three states only
   assign in_handler = (state_r == ST_PRIV_HANDLER);
   assign is_user    = (state_r == ST_USER_THREAD);
   assign use_psp    = !in_handler && ctrl_r[CTRL_SPSEL];
   // stack pointer low bits read zero
   assign sp_view    = use_psp ? {psp_r[XW-1:2], 2'b00} : {msp_r[XW-1:2], 2'b00};

   // operating state machine, handler never at user level
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r <= ST_PRIV_THREAD;
      end else begin
         case (state_r)
            ST_PRIV_THREAD, ST_USER_THREAD: begin
               if (exc_entry) begin
                  state_r <= ST_PRIV_HANDLER;
               end else if (sreg_wr && sreg_addr == OFS_CTRL && !is_user) begin
                  state_r <= sreg_wdata[CTRL_USER] ? ST_USER_THREAD : ST_PRIV_THREAD;
               end
            end
            ST_PRIV_HANDLER: begin
               if (exc_return && exc_ret_thread) begin
                  state_r <= ctrl_r[CTRL_USER] ? ST_USER_THREAD : ST_PRIV_THREAD;
               end
            end
            default: state_r <= ST_PRIV_THREAD;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // privilege checks and fault
   // ---------------------------------------------------------------
   // high registers unreachable by narrow encodings
   assign hi_denied  = gpr_we && gpr_narrow && (gpr_waddr > IDX_LOW_MAX)
                       && (gpr_waddr < IDX_SP);
   // user level blocked from writing special registers other than status, and from restricted ops
   assign priv_deny  = is_user && (restricted_op || (sreg_wr && sreg_addr != OFS_STATUS));
   assign status_wr  = sreg_wr && sreg_addr == OFS_STATUS;
   assign tbit_clear = status_wr && !sreg_wdata[TBIT];
   assign fault_nxt  = priv_deny || tbit_clear || hi_denied;

   // fault pulse registered so the output comes from a flip-flop
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         fault_req <= 1'b0;
      end else begin
         fault_req <= fault_nxt;
      end
   end

   // ---------------------------------------------------------------
   // general registers
   // ---------------------------------------------------------------
   // thirteen 32-bit general registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         for (int i = 0; i < 13; i++) gpr_r[i] <= RST_ZERO;
      end else if (gpr_we && !hi_denied && gpr_waddr < IDX_SP) begin
         gpr_r[gpr_waddr] <= gpr_wdata;
      end
   end

   // stack bank write, selected copy only; alignment enforced on store
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         msp_r <= RST_ZERO;
         psp_r <= RST_ZERO;
      end else begin
         if (gpr_we && gpr_waddr == IDX_SP) begin
            // write goes to the active bank
            if (use_psp) psp_r <= {gpr_wdata[XW-1:2], 2'b00};
            else         msp_r <= {gpr_wdata[XW-1:2], 2'b00};
         end else if (sreg_wr && !is_user && sreg_addr == OFS_MSP) begin
            msp_r <= {sreg_wdata[XW-1:2], 2'b00};
         end else if (sreg_wr && !is_user && sreg_addr == OFS_PSP) begin
            psp_r <= {sreg_wdata[XW-1:2], 2'b00};
         end
      end
   end

   // program counter; wide instructions step four, narrow two
   assign next_pc = pc_r + (pc_step_wide ? 32'h0000_0004 : 32'h0000_0002);

   // call writes return address into link register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lr_r <= RST_ZERO;
      end else if (call_req) begin
         lr_r <= {next_pc[XW-1:1], 1'b1};
      end else if (gpr_we && gpr_waddr == IDX_LR) begin
         lr_r <= gpr_wdata;
      end
   end

   // program counter bit zero forced low
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_r <= RST_ZERO;
      end else if (pc_load) begin
         pc_r <= {pc_target[XW-1:1], 1'b0};
      end else if (gpr_we && gpr_waddr == IDX_PC) begin
         pc_r <= {gpr_wdata[XW-1:1], 1'b0};
      end else if (pc_step) begin
         pc_r <= {next_pc[XW-1:1], 1'b0};
      end
   end

   // read mux and fetch address registered
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gpr_rdata  <= RST_ZERO;
         fetch_addr <= RST_ZERO;
      end else begin
         fetch_addr <= pc_r;
         case (gpr_raddr)
            IDX_SP:  gpr_rdata <= sp_view;
            IDX_LR:  gpr_rdata <= lr_r;
            IDX_PC:  gpr_rdata <= pc_r;
            default: gpr_rdata <= gpr_r[gpr_raddr];
         endcase
      end
   end

   // ---------------------------------------------------------------
   // status word
   // ---------------------------------------------------------------
   // field layout of the combined word
   always_comb begin
      status_word                  = RST_ZERO;
      status_word[FLAG_HI:FLAG_LO] = flags_r;
      status_word[TBIT]            = 1'b1;
      status_word[IT_HI:IT_LO]     = it_r;
      status_word[ICI_HI:ICI_LO]   = ici_r;
      status_word[EXC_HI:EXC_LO]   = exc_r;
   end

   // condition flags; flags from the alu win over a move
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         flags_r <= 5'h00;
      end else if (flags_we) begin
         flags_r <= flags_in;
      end else if (status_wr && !tbit_clear) begin
         flags_r <= sreg_wdata[FLAG_HI:FLAG_LO];
      end
   end

   // execution control bits, privileged writes only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ici_r <= 6'h00;
         it_r  <= 2'h0;
      end else if (status_wr && !tbit_clear && !is_user) begin
         ici_r <= sreg_wdata[ICI_HI:ICI_LO];
         it_r  <= sreg_wdata[IT_HI:IT_LO];
      end
   end

   // exception number tracks the one in service
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         exc_r <= 9'h000;
      end else if (exc_entry) begin
         exc_r <= exc_num;
      end else if (exc_return && exc_ret_thread) begin
         exc_r <= 9'h000;
      end
   end

   // ---------------------------------------------------------------
   // masks and mode control
   // ---------------------------------------------------------------
   // masks writable only at privileged level; user writes fault instead
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gmask_r <= 1'b0;
         fmask_r <= 1'b0;
         prio_r  <= '0;
      end else begin
         if (sreg_wr && !is_user && sreg_addr == OFS_GMASK) gmask_r <= sreg_wdata[0];
         // fault mask drops on return other than from NMI, so a handler cannot leave it set
         if (exc_return && exc_num != EXC_NMI) fmask_r <= 1'b0;
         else if (sreg_wr && !is_user && sreg_addr == OFS_FMASK) fmask_r <= sreg_wdata[0];
         if (sreg_wr && !is_user && sreg_addr == OFS_PRIO) prio_r <= sreg_wdata[PW-1:0];
      end
   end

   // stack select held zero in handler mode unless set by a control write in the entry cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_r <= 2'b00;
      end else if (sreg_wr && !is_user && sreg_addr == OFS_CTRL) begin
         // stack select only takes effect outside handler
         ctrl_r[CTRL_USER]  <= sreg_wdata[CTRL_USER];
         ctrl_r[CTRL_SPSEL] <= in_handler ? 1'b0 : sreg_wdata[CTRL_SPSEL];
      end else if (exc_entry) begin
         ctrl_r[CTRL_SPSEL] <= 1'b0;
      end
   end

   // masking decision for the pending interrupt
   always_comb begin
      mask_block = 1'b0;
      if (irq_num != EXC_NMI) begin
         if (fmask_r) mask_block = 1'b1;
         else if (gmask_r && irq_num != EXC_HARD) mask_block = 1'b1;
         else if (prio_r != '0 && irq_prio >= prio_r && irq_num != EXC_HARD)
            mask_block = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_take <= 1'b0;
      end else begin
         irq_take <= irq_pend && !mask_block;
      end
   end

   // special register read port, data one cycle after the strobe
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sreg_rdata <= RST_ZERO;
      end else if (sreg_rd) begin
         case (sreg_addr)
            OFS_STATUS: sreg_rdata <= status_word;
            OFS_GMASK:  sreg_rdata <= {31'h0, gmask_r};
            OFS_FMASK:  sreg_rdata <= {31'h0, fmask_r};
            OFS_PRIO:   sreg_rdata <= {{(XW-PW){1'b0}}, prio_r};
            OFS_CTRL:   sreg_rdata <= {30'h0, ctrl_r};
            OFS_MSP:    sreg_rdata <= {msp_r[XW-1:2], 2'b00};
            OFS_PSP:    sreg_rdata <= {psp_r[XW-1:2], 2'b00};
            OFS_MODE:   sreg_rdata <= {30'h0, in_handler, is_user};
            default:    sreg_rdata <= RST_ZERO;
         endcase
      end else begin
         sreg_rdata <= RST_ZERO;
      end
   end

   // ---------------------------------------------------------------
   // data address path
   // ---------------------------------------------------------------
   // alias word maps to one sram bit; other addresses pass unaligned
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mem_addr    <= RST_ZERO;
         mem_bit     <= 5'h00;
         mem_bitband <= 1'b0;
      end else if (data_addr[XW-1:20] == BB_ALIAS[XW-1:20]) begin
         mem_addr    <= BB_REGION | {12'h000, 5'h00, data_addr[19:7], 2'b00};
         mem_bit     <= data_addr[6:2];
         mem_bitband <= 1'b1;
      end else begin
         mem_addr    <= data_addr;
         mem_bit     <= 5'h00;
         mem_bitband <= 1'b0;
      end
   end

   // mode outputs registered
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         handler_mode <= 1'b0;
         user_level   <= 1'b0;
      end else begin
         handler_mode <= in_handler;
         user_level   <= is_user;
      end
   end
endmodule : csr_core_state

// ### include/csr_pkg.sv
// constants and types for the core architectural state block
//
// Contract
// - only privileged handler, privileged thread and user thread states exist.
// - user-level access to restricted resources is blocked and raises a fault.
// - handler mode while servicing an exception, thread mode otherwise.
// - all sixteen core registers are 32 bits wide.
// - low registers reach all encodings; high registers 8-12 not all 16-bit.
// - process stack used only in thread mode with stack select set, main otherwise.
// - stack pointer low two bits ignored and read zero.
// - a subroutine call writes the return address into the link register.
// - program counter bit zero ignored, fetch halfword aligned.
// - condition flags sit in status bits 27 to 31.
// - current exception number sits in status bits 0 to 8.
// - continuable and if-then state sit in bits 10-15 and 25-26.
// - status bit 24 reads one; clearing it raises a fault.
// - general mask blocks everything except nonmaskable and hard fault.
// - fault mask blocks everything except nonmaskable.
// - priority threshold blocks priorities at or above it; zero disables.
// - mode control bit 0 selects thread privilege, one is user.
// - mode control bit 1 selects process stack in thread mode.
// - stack select bit is zero whenever in handler mode; a control write in the entry cycle leaves it set.
// - bit-band aliasing gives atomic single-bit access to the sram region.
// - unaligned data accesses are accepted.
package csr_pkg;
   localparam int XLEN          = 32;
   localparam int PRIO_W        = 9;
   localparam int EXC_W         = 9;
   // register file indices
   localparam logic [3:0] IDX_SP = 4'hD;
   localparam logic [3:0] IDX_LR = 4'hE;
   localparam logic [3:0] IDX_PC = 4'hF;
   localparam logic [3:0] IDX_LOW_MAX = 4'h7;
   // special register bus offsets (word index times four)
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_GMASK    = 8'h04;
   localparam logic [7:0] OFS_FMASK    = 8'h08;
   localparam logic [7:0] OFS_PRIO     = 8'h0C;
   localparam logic [7:0] OFS_CTRL     = 8'h10;
   localparam logic [7:0] OFS_MSP      = 8'h14;
   localparam logic [7:0] OFS_PSP      = 8'h18;
   localparam logic [7:0] OFS_MODE     = 8'h1C;
   // status word fields
   localparam int FLAG_LO  = 27;
   localparam int FLAG_HI  = 31;
   localparam int EXC_LO   = 0;
   localparam int EXC_HI   = 8;
   localparam int ICI_LO   = 10;
   localparam int ICI_HI   = 15;
   localparam int IT_LO    = 25;
   localparam int IT_HI    = 26;
   localparam int TBIT     = 24;
   // mode control fields
   localparam int CTRL_USER = 0;
   localparam int CTRL_SPSEL = 1;
   // exception numbers
   localparam logic [EXC_W-1:0] EXC_NMI  = 9'h002;
   localparam logic [EXC_W-1:0] EXC_HARD = 9'h003;
   localparam logic [EXC_W-1:0] EXC_USAGE = 9'h006;
   // bit-band region
   localparam logic [XLEN-1:0] BB_REGION = 32'h2000_0000;
   localparam logic [XLEN-1:0] BB_ALIAS  = 32'h2200_0000;
   localparam logic [XLEN-1:0] RST_ZERO  = 32'h0000_0000;
   typedef enum {ST_PRIV_THREAD, ST_USER_THREAD, ST_PRIV_HANDLER} csr_state_type;
endpackage : csr_pkg

// ### test/csr_core_state_bench.sv
// self-checking bench for the core state block
`timescale 1ns/100ps
module csr_core_state_bench
   import csr_pkg::*;
;
   logic        clock, sys_rst, gpr_we, gpr_narrow, pc_load, pc_step, pc_step_wide;
   logic        call_req, flags_we, exc_entry, exc_return, exc_ret_thread, irq_pend;
   logic        sreg_wr, sreg_rd, restricted_op, irq_take, mem_bitband, fault_req;
   logic        handler_mode, user_level;
   logic [3:0]  gpr_waddr, gpr_raddr;
   logic [4:0]  flags_in, mem_bit;
   logic [7:0]  sreg_addr;
   logic [8:0]  exc_num, irq_num, irq_prio;
   logic [31:0] gpr_wdata, gpr_rdata, pc_target, fetch_addr, sreg_wdata, sreg_rdata;
   logic [31:0] data_addr, mem_addr;
   int          mismatches, n_compared;
   localparam logic [7:0] rst_ofs [5] = '{OFS_GMASK, OFS_FMASK, OFS_PRIO, OFS_CTRL, OFS_MODE};

   csr_core_state csr_core_state_inst (.*);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   always #2.5 clock = ~clock;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // register write, then fault pulse
   task automatic sw(input logic [7:0] a, input logic [31:0] d, input logic f);
      @(posedge clock);
      sreg_wr <= 1'b1;
      sreg_addr <= a;
      sreg_wdata <= d;
      @(posedge clock);
      sreg_wr <= 1'b0;
      #1 check("sreg fault", 32'(fault_req), 32'(f));
   endtask : sw

   // read data stand one cycle
   task automatic sr(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      sreg_rd <= 1'b1;
      sreg_addr <= a;
      @(posedge clock);
      sreg_rd <= 1'b0;
      #1 v = sreg_rdata;
   endtask : sr

   task automatic gw(input logic [3:0] a, input logic [31:0] d, input logic n, input logic f);
      @(posedge clock);
      gpr_we <= 1'b1;
      gpr_waddr <= a;
      gpr_wdata <= d;
      gpr_narrow <= n;
      @(posedge clock);
      gpr_we <= 1'b0;
      #1 check("gpr fault", 32'(fault_req), 32'(f));
   endtask : gw

   task automatic gr(input logic [3:0] a, output logic [31:0] v);
      @(posedge clock);
      gpr_raddr <= a;
      @(posedge clock);
      #1 v = gpr_rdata;
   endtask : gr

   task automatic irq(input logic [8:0] num, input logic [8:0] prio, input logic exp);
      @(posedge clock);
      irq_pend <= 1'b1;
      irq_num <= num;
      irq_prio <= prio;
      @(posedge clock);
      irq_pend <= 1'b0;
      #1 check("irq take", 32'(irq_take), 32'(exp));
   endtask : irq

   // exception entry or return; mode outputs lag a cycle
   task automatic exc(input logic enter);
      @(posedge clock);
      exc_entry <= enter;
      exc_return <= !enter;
      exc_num <= 9'h00F;
      exc_ret_thread <= 1'b1;
      @(posedge clock);
      exc_entry <= 1'b0;
      exc_return <= 1'b0;
      #6;
   endtask : exc

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] v;
      check("handler", 32'(handler_mode), 32'h0);
      check("user", 32'(user_level), 32'h0);
      foreach (rst_ofs[i]) begin
         sr(rst_ofs[i], v);
         check("reset reg", v, 32'h0);
      end
      sr(OFS_STATUS, v);
      check("state bit", 32'(v[TBIT]), 32'h1);
      sr(8'h40, v);
      check("unmapped", v, 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs;
      logic [31:0] v;
      for (int i = 0; i < 13; i++) begin
         gw(4'(i), 32'hA5C3_0000 | 32'(i), 1'b0, 1'b0);
      end
      for (int i = 0; i < 13; i++) begin
         gr(4'(i), v);
         check("gpr", v, 32'hA5C3_0000 | 32'(i));
      end
      // narrow reach, boundaries 7 and 12
      gw(4'hC, 32'h0, 1'b1, 1'b1);
      gw(4'h7, 32'h77, 1'b1, 1'b0);
      gr(4'hC, v);
      check("narrow drop", v, 32'hA5C3_000C);
      gr(4'h7, v);
      check("narrow low", v, 32'h77);
      gw(4'hD, 32'h1234_5677, 1'b0, 1'b0);
      gr(4'hD, v);
      check("stack", v, 32'h1234_5674);
      sr(8'h14, v);
      check("main stack", v, 32'h1234_5674);
      $display("test regs done");
   endtask : t_regs

   task automatic t_flow;
      logic [31:0] v;
      @(posedge clock);
      pc_load <= 1'b1;
      pc_target <= 32'h0000_1001;
      @(posedge clock);
      pc_load <= 1'b0;
      @(posedge clock);
      #1 check("fetch", fetch_addr, 32'h0000_1000);
      @(posedge clock);
      call_req <= 1'b1;
      @(posedge clock);
      call_req <= 1'b0;
      gr(4'hE, v);
      check("link", v, 32'h0000_1003);
      $display("test flow done");
   endtask : t_flow

   task automatic t_modes;
      logic [31:0] v;
      sw(OFS_CTRL, 32'h3, 1'b0);
      gw(4'hD, 32'h0000_8889, 1'b0, 1'b0);
      check("user", 32'(user_level), 32'h1);
      sw(OFS_GMASK, 32'h1, 1'b1);
      @(posedge clock);
      restricted_op <= 1'b1;
      @(posedge clock);
      restricted_op <= 1'b0;
      #1 check("op fault", 32'(fault_req), 32'h1);
      sw(OFS_STATUS, 32'hF900_0000, 1'b0);
      sr(OFS_STATUS, v);
      check("flags", 32'(v[FLAG_HI:FLAG_LO]), 32'h1F);
      exc(1'b1);
      check("handler", 32'(handler_mode), 32'h1);
      check("priv", 32'(user_level), 32'h0);
      sr(OFS_STATUS, v);
      check("exc num", 32'(v[EXC_HI:EXC_LO]), 32'h00F);
      gr(4'hD, v);
      check("handler stack", v, 32'h1234_5674);
      sr(8'h18, v);
      check("process stack", v, 32'h0000_8888);
      sr(OFS_CTRL, v);
      check("ctrl", v, 32'h1);
      sr(OFS_GMASK, v);
      check("gmask kept", v, 32'h0);
      exc(1'b0);
      check("thread", 32'(handler_mode), 32'h0);
      check("back user", 32'(user_level), 32'h1);
      sr(OFS_STATUS, v);
      check("exc clr", 32'(v[EXC_HI:EXC_LO]), 32'h0);
      // back to privileged thread
      exc(1'b1);
      sw(OFS_CTRL, 32'h0, 1'b0);
      exc(1'b0);
      check("priv thread", 32'(user_level), 32'h0);
      sw(OFS_STATUS, 32'h0, 1'b1);
      sw(OFS_STATUS, 32'h0700_FC00, 1'b0);
      @(posedge clock);
      flags_we <= 1'b1;
      flags_in <= 5'h0A;
      @(posedge clock);
      flags_we <= 1'b0;
      sr(OFS_STATUS, v);
      check("alu flags", 32'(v[FLAG_HI:FLAG_LO]), 32'h0A);
      check("bit kept", 32'(v[TBIT]), 32'h1);
      check("exec bits", v & 32'h0600_FC00, 32'h0600_FC00);
      $display("test modes done");
   endtask : t_modes

   task automatic t_masks;
      irq(9'h010, 9'h020, 1'b1);
      sw(OFS_PRIO, 32'h20, 1'b0);
      irq(9'h010, 9'h020, 1'b0);
      irq(9'h010, 9'h01F, 1'b1);
      sw(OFS_PRIO, 32'h0, 1'b0);
      sw(OFS_GMASK, 32'h1, 1'b0);
      irq(9'h010, 9'h001, 1'b0);
      irq(EXC_HARD, 9'h001, 1'b1);
      irq(EXC_NMI, 9'h001, 1'b1);
      sw(OFS_GMASK, 32'h0, 1'b0);
      sw(OFS_FMASK, 32'h1, 1'b0);
      irq(9'h010, 9'h001, 1'b0);
      irq(EXC_HARD, 9'h001, 1'b0);
      irq(EXC_NMI, 9'h001, 1'b1);
      $display("test masks done");
   endtask : t_masks

   task automatic t_bitband;
      @(posedge clock);
      data_addr <= 32'h2200_0214;
      @(posedge clock);
      #1 check("bb addr", mem_addr, 32'h2000_0010);
      check("bb bit", 32'(mem_bit), 32'h5);
      check("bb flag", 32'(mem_bitband), 32'h1);
      @(posedge clock);
      data_addr <= 32'h2000_0003;
      @(posedge clock);
      #1 check("odd addr", mem_addr, 32'h2000_0003);
      check("no bb", 32'(mem_bitband), 32'h0);
      $display("test bitband done");
   endtask : t_bitband

   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      {clock, gpr_we, gpr_narrow, pc_load, pc_step, pc_step_wide, call_req} = '0;
      {flags_we, exc_entry, exc_return, exc_ret_thread, irq_pend, sreg_wr} = '0;
      {sreg_rd, restricted_op, gpr_waddr, gpr_raddr, flags_in, sreg_addr} = '0;
      {exc_num, irq_num, irq_prio, gpr_wdata, pc_target, sreg_wdata, data_addr} = '0;
      mismatches = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      #1;
      t_reset();
      t_regs();
      t_flow();
      t_modes();
      t_masks();
      t_bitband();
      stop_test();
   end

   // tests need some 170 cycles
   initial begin
      #10000;
      mismatches++;
      stop_test();
   end
endmodule : csr_core_state_bench

// ### test/csr_core_state_monitor.sv
// concurrent checks on the ports of the core state block
`timescale 1ns/100ps
module csr_core_state_monitor
   import csr_pkg::*;
(
   input wire logic        clock,
   input wire logic        sys_rst,
   input wire logic [3:0]  gpr_waddr,
   input wire logic        gpr_we,
   input wire logic        gpr_narrow,
   input wire logic [3:0]  gpr_raddr,
   input wire logic [31:0] gpr_rdata,
   input wire logic        pc_load,
   input wire logic [31:0] pc_target,
   input wire logic [31:0] fetch_addr,
   input wire logic        exc_entry,
   input wire logic        exc_return,
   input wire logic        exc_ret_thread,
   input wire logic        irq_take,
   input wire logic [7:0]  sreg_addr,
   input wire logic [31:0] sreg_wdata,
   input wire logic        sreg_wr,
   input wire logic        sreg_rd,
   input wire logic [31:0] sreg_rdata,
   input wire logic        restricted_op,
   input wire logic        fault_req,
   input wire logic        handler_mode,
   input wire logic        user_level
);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // one clock domain
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   a_no_user_handler: assert property (!(handler_mode && user_level))
      else $error("user level seen in handler mode");
   a_entry_to_handler: assert property (exc_entry && !exc_return |-> ##2 handler_mode)
      else $error("exception entry did not give handler mode");
   a_return_to_thread: assert property (exc_return && exc_ret_thread && !exc_entry
      |-> ##2 !handler_mode)
      else $error("exception return did not give thread mode");
   a_user_op_fault: assert property (restricted_op && user_level && !exc_entry
      && !$past(exc_entry) |=> fault_req)
      else $error("restricted op at user level raised no fault");
   a_narrow_high_fault: assert property (gpr_we && gpr_narrow
      && gpr_waddr inside {[4'h8:4'hC]} |=> fault_req)
      else $error("narrow write to high register raised no fault");
   a_tbit_clear_fault: assert property (sreg_wr && sreg_addr == 8'h00
      && !sreg_wdata[TBIT] |=> fault_req)
      else $error("clearing the status state bit raised no fault");
   a_tbit_reads_one: assert property (sreg_rd && sreg_addr == 8'h00 |=> sreg_rdata[TBIT])
      else $error("status state bit read as zero");
   a_stack_aligned: assert property (gpr_raddr == 4'hD |=> gpr_rdata[1:0] == 2'b00)
      else $error("stack read not word aligned");
   a_jump_aligned: assert property (pc_load |-> ##2
      fetch_addr == ($past(pc_target, 2) & 32'hFFFF_FFFE))
      else $error("fetch address after jump wrong");
   a_handler_main: assert property (handler_mode && sreg_rd && sreg_addr == 8'h10
      |=> !sreg_rdata[CTRL_SPSEL])
      else $error("stack select read as one in handler mode");

   // main scenarios reached
   c_handler: cover property (exc_entry ##1 handler_mode);
   c_fault: cover property (fault_req);
   c_take: cover property (irq_take);
   c_user: cover property ($rose(user_level));
endmodule : csr_core_state_monitor

bind csr_core_state csr_core_state_monitor csr_core_state_monitor_inst (.*);
